/* File: rtl/usb_std_request_handler.sv */
// Standard request handler of the USB device core, control endpoint side
//
// Summary of operation
// R1: Descriptor and synch-frame requests go to firmware; the rest are handled here.
// R2: Set-configuration and set-interface run fully in hardware, status included.
// R3: Active configuration, interface and alternate setting are kept readable.
// R4: Clear-feature clears an endpoint halt or the remote-wakeup enable.
// R5: Set-feature sets an endpoint halt or the remote-wakeup enable.
// R6: A new address takes effect only after its status stage succeeds.
// R7: Data and status stages use the address the setup was sent to.
// R8: Other requests finish their operation before their status is acknowledged.
// R9: Every get-descriptor request is passed to firmware.
// R10: Firmware supplies device, configuration and string descriptors in order.
// R11: Firmware returns the whole configuration descriptor set in one reply.
// R12: Get-configuration returns the configuration value, zero when unconfigured.
// R13: Get-interface is valid only when configured and returns the alternate.
// R14: Get-interface is answered here; firmware only gets a notification.
// R15: Get-status returns the device, interface or endpoint status.
// R16: Firmware reports the frame number where the sync pattern began.
// R17: Requests to absent interfaces or endpoints are never stalled.
// R18: Forwarded setups raise the setup interrupt and clear buffer flags.
// R19: A selection change by set-configuration or set-interface raises an interrupt.
// R20: Firmware enables the status acknowledge; until then a status interrupt fires.
// R21: Class and vendor requests are forwarded like forwarded standard ones.
module usb_std_request_handler #(
	parameter logic [15:0] EP_MASK = 16'hffff,
	parameter int IFACES = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic setup_valid,
	input wire logic [63:0] setup_data,
	input wire logic [6:0] setup_dev_addr,
	input wire logic status_req,
	input wire logic status_done,
	input wire logic ep0_status_ack_enable,
	input wire logic self_powered,
	input wire logic [15:0] iface_status,
	output logic [6:0] match_addr,
	output logic setup_irq,
	output logic data_flags_clear,
	output logic status_stage_irq,
	output logic selection_change_irq,
	output logic get_iface_seen,
	output logic status_ack,
	output logic status_nak,
	output logic reply_valid,
	output logic [15:0] reply_data,
	output logic [1:0] reply_len,
	output logic [3:0] active_cfg,
	output logic [3:0] active_iface,
	output logic [3:0] active_alt,
	output logic configured,
	output logic [15:0] ep_halt,
	output logic remote_wake_en
);

	// ****************************************
	// Decoder and alternate setting store
	// ****************************************
	req_if rq ();

	logic alt_clr;
	logic alt_we;
	logic [3:0] alt_rd;

	req_decoder u_dec (
		.clk(clk),
		.rst(rst),
		.setup_valid(setup_valid),
		.setup_data(setup_data),
		.rq(rq)
	);

	alt_setting_store #(
		.IFACES(IFACES),
		.ALT_W(4)
	) u_alt (
		.clk(clk),
		.rst(rst),
		.clear_all(alt_clr),
		.wr_en(alt_we),
		.wr_idx(rq.w_index[3:0]),
		.wr_alt(rq.w_value[3:0]),
		.rd_idx(rq.w_index[3:0]),
		.rd_alt(alt_rd)
	);

	// ****************************************
	// State
	// ****************************************
	usb_req_pkg::xfer_state_t state_r, state_nxt;
	logic [6:0] addr_r, addr_nxt;
	logic [6:0] new_addr_r, new_addr_nxt;
	logic [6:0] match_r, match_nxt;
	logic [3:0] cfg_r, cfg_nxt;
	logic [3:0] iface_r, iface_nxt;
	logic [3:0] alt_r, alt_nxt;
	logic cfgd_r, cfgd_nxt;
	logic [15:0] halt_r, halt_nxt;
	logic wake_r, wake_nxt;
	logic sirq_r, sirq_nxt;
	logic fclr_r, fclr_nxt;
	logic stirq_r, stirq_nxt;
	logic selirq_r, selirq_nxt;
	logic gin_r, gin_nxt;
	logic ack_r, ack_nxt;
	logic nak_r, nak_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [1:0] rlen_r, rlen_nxt;
	logic ep_ok;

	// Endpoint addressed by wIndex and whether this core implements it
	assign ep_ok = EP_MASK[rq.w_index[3:0]];

	// ****************************************
	// Request execution and status stage
	// ****************************************
	// Operations land the cycle after decode, so they are done long before
	// any status token can arrive; a status token seen during decode is
	// answered with NAK so the host retries rather than racing the update.
	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		new_addr_nxt = new_addr_r;
		match_nxt = match_r;
		cfg_nxt = cfg_r;
		iface_nxt = iface_r;
		alt_nxt = alt_r;
		cfgd_nxt = cfgd_r;
		halt_nxt = halt_r;
		wake_nxt = wake_r;
		rdata_nxt = rdata_r;
		rlen_nxt = rlen_r;
		sirq_nxt = 1'b0;
		fclr_nxt = 1'b0;
		stirq_nxt = 1'b0;
		selirq_nxt = 1'b0;
		gin_nxt = 1'b0;
		ack_nxt = 1'b0;
		nak_nxt = 1'b0;
		rvalid_nxt = 1'b0;
		alt_clr = 1'b0;
		alt_we = 1'b0;

		if (rq.valid) begin
			state_nxt = usb_req_pkg::S_HW_DONE; // R8
			case (rq.kind)
				usb_req_pkg::K_GET_STATUS: begin
					rvalid_nxt = 1'b1; // R15
					rlen_nxt = usb_req_pkg::LEN_WORD;
					rdata_nxt = 16'h0000;
					case (rq.recipient)
						usb_req_pkg::RCPT_DEVICE: begin
							rdata_nxt[usb_req_pkg::STS_SELF_POWERED] = self_powered;
							rdata_nxt[usb_req_pkg::STS_REMOTE_WAKE] = wake_r;
						end
						usb_req_pkg::RCPT_IFACE: rdata_nxt = iface_status;
						usb_req_pkg::RCPT_EP: begin
							rdata_nxt[usb_req_pkg::STS_HALT] = halt_r[rq.w_index[3:0]];
						end
						default: rdata_nxt = 16'h0000;
					endcase
				end
				usb_req_pkg::K_CLEAR_FEATURE: begin
					// Unknown targets are accepted silently, never stalled
					if (rq.recipient == usb_req_pkg::RCPT_DEVICE &&
							rq.w_value == usb_req_pkg::FEAT_REMOTE_WAKE) begin
						wake_nxt = 1'b0; // R4
					end else if (rq.recipient == usb_req_pkg::RCPT_EP &&
							rq.w_value == usb_req_pkg::FEAT_EP_HALT && ep_ok) begin
						halt_nxt[rq.w_index[3:0]] = 1'b0; // R4
					end
				end
				usb_req_pkg::K_SET_FEATURE: begin
					if (rq.recipient == usb_req_pkg::RCPT_DEVICE &&
							rq.w_value == usb_req_pkg::FEAT_REMOTE_WAKE) begin
						wake_nxt = 1'b1; // R5
					end else if (rq.recipient == usb_req_pkg::RCPT_EP &&
							rq.w_value == usb_req_pkg::FEAT_EP_HALT && ep_ok) begin
						halt_nxt[rq.w_index[3:0]] = 1'b1; // R5
					end
				end
				usb_req_pkg::K_SET_ADDRESS: begin
					new_addr_nxt = rq.w_value[6:0]; // R6
					state_nxt = usb_req_pkg::S_ADDR_WAIT;
				end
				usb_req_pkg::K_GET_CONFIG: begin
					rvalid_nxt = 1'b1;
					rlen_nxt = usb_req_pkg::LEN_BYTE;
					rdata_nxt = {12'h000, cfgd_r ? cfg_r : 4'h0}; // R12
				end
				usb_req_pkg::K_SET_CONFIG: begin
					cfg_nxt = rq.w_value[3:0]; // R2
					cfgd_nxt = (rq.w_value[3:0] != 4'h0);
					iface_nxt = usb_req_pkg::SEL_RST;
					alt_nxt = usb_req_pkg::SEL_RST;
					alt_clr = 1'b1; // R3
					selirq_nxt = (rq.w_value[3:0] != cfg_r) ||
						(iface_r != usb_req_pkg::SEL_RST) ||
						(alt_r != usb_req_pkg::SEL_RST); // R19
				end
				usb_req_pkg::K_GET_IFACE: begin
					gin_nxt = 1'b1; // R14
					rvalid_nxt = 1'b1;
					// Unconfigured: empty reply instead of a STALL handshake
					rlen_nxt = cfgd_r ? usb_req_pkg::LEN_BYTE : usb_req_pkg::LEN_NONE; // R13
					rdata_nxt = {12'h000, cfgd_r ? alt_rd : 4'h0}; // R13
				end
				usb_req_pkg::K_SET_IFACE: begin
					if (cfgd_r) begin
						iface_nxt = rq.w_index[3:0]; // R2
						alt_nxt = rq.w_value[3:0]; // R3
						alt_we = 1'b1;
						selirq_nxt = (rq.w_index[3:0] != iface_r) ||
							(rq.w_value[3:0] != alt_r); // R19
					end
				end
				usb_req_pkg::K_FORWARD: begin
					sirq_nxt = 1'b1; // R18
					fclr_nxt = 1'b1; // R18
					state_nxt = usb_req_pkg::S_CPU_WAIT; // R1
				end
				default: begin
					// Unsupported standard request: completes quietly, R17 applies
					state_nxt = usb_req_pkg::S_HW_DONE; // R17
				end
			endcase
		end

		// Status token from the host on the control endpoint
		if (status_req) begin
			case (state_r)
				usb_req_pkg::S_HW_DONE: ack_nxt = 1'b1; // R2
				usb_req_pkg::S_ADDR_WAIT: ack_nxt = 1'b1;
				usb_req_pkg::S_CPU_WAIT: begin
					// Firmware holds the handshake until it has finished its part
					ack_nxt = ep0_status_ack_enable; // R20
					nak_nxt = !ep0_status_ack_enable;
					stirq_nxt = !ep0_status_ack_enable;
				end
				default: nak_nxt = 1'b1; // R8
			endcase
		end

		// Successful status handshake closes the transfer
		if (status_done && state_r != usb_req_pkg::S_DECODE) begin
			if (state_r == usb_req_pkg::S_ADDR_WAIT) begin
				addr_nxt = new_addr_r; // R6
				match_nxt = new_addr_r; // R6
			end
			state_nxt = usb_req_pkg::S_IDLE;
		end

		// A fresh setup abandons whatever transfer was open, pending address too
		if (setup_valid) begin
			match_nxt = setup_dev_addr; // R7
			state_nxt = usb_req_pkg::S_DECODE;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= usb_req_pkg::S_IDLE;
			addr_r <= usb_req_pkg::ADDR_RST;
			new_addr_r <= usb_req_pkg::ADDR_RST;
			match_r <= usb_req_pkg::ADDR_RST;
			cfg_r <= usb_req_pkg::SEL_RST;
			iface_r <= usb_req_pkg::SEL_RST;
			alt_r <= usb_req_pkg::SEL_RST;
			cfgd_r <= 1'b0;
			halt_r <= 16'h0000;
			wake_r <= 1'b0;
			sirq_r <= 1'b0;
			fclr_r <= 1'b0;
			stirq_r <= 1'b0;
			selirq_r <= 1'b0;
			gin_r <= 1'b0;
			ack_r <= 1'b0;
			nak_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 16'h0000;
			rlen_r <= usb_req_pkg::LEN_NONE;
		end else begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			new_addr_r <= new_addr_nxt;
			match_r <= match_nxt;
			cfg_r <= cfg_nxt;
			iface_r <= iface_nxt;
			alt_r <= alt_nxt;
			cfgd_r <= cfgd_nxt;
			halt_r <= halt_nxt;
			wake_r <= wake_nxt;
			sirq_r <= sirq_nxt;
			fclr_r <= fclr_nxt;
			stirq_r <= stirq_nxt;
			selirq_r <= selirq_nxt;
			gin_r <= gin_nxt;
			ack_r <= ack_nxt;
			nak_r <= nak_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rlen_r <= rlen_nxt;
		end
	end

	// ****************************************
	// Outputs, all straight from flops
	// ****************************************
	assign match_addr = match_r;
	assign setup_irq = sirq_r;
	assign data_flags_clear = fclr_r;
	assign status_stage_irq = stirq_r;
	assign selection_change_irq = selirq_r;
	assign get_iface_seen = gin_r;
	assign status_ack = ack_r;
	assign status_nak = nak_r;
	assign reply_valid = rvalid_r;
	assign reply_data = rdata_r;
	assign reply_len = rlen_r;
	assign active_cfg = cfg_r;
	assign active_iface = iface_r;
	assign active_alt = alt_r;
	assign configured = cfgd_r;
	assign ep_halt = halt_r;
	assign remote_wake_en = wake_r;

endmodule

/* File: include/usb_req_pkg.sv */
// Constants, encodings and types shared by the standard request handler
package usb_req_pkg;

	// ****************************************
	// Setup packet field layout
	// ****************************************
	localparam int BMRT_LSB = 0;
	localparam int BREQ_LSB = 8;
	localparam int WVAL_LSB = 16;
	localparam int WIDX_LSB = 32;
	localparam int TYPE_LSB = 5;
	localparam logic [1:0] TYPE_STANDARD = 2'h0;

	// ****************************************
	// Standard request codes
	// ****************************************
	localparam logic [7:0] REQ_GET_STATUS = 8'h00;
	localparam logic [7:0] REQ_CLEAR_FEATURE = 8'h01;
	localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
	localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
	localparam logic [7:0] REQ_GET_DESCRIPTOR = 8'h06;
	localparam logic [7:0] REQ_SET_DESCRIPTOR = 8'h07;
	localparam logic [7:0] REQ_GET_CONFIG = 8'h08;
	localparam logic [7:0] REQ_SET_CONFIG = 8'h09;
	localparam logic [7:0] REQ_GET_IFACE = 8'h0a;
	localparam logic [7:0] REQ_SET_IFACE = 8'h0b;
	localparam logic [7:0] REQ_SYNCH_FRAME = 8'h0c;

	// ****************************************
	// Recipients, feature selectors, status bits
	// ****************************************
	localparam logic [4:0] RCPT_DEVICE = 5'h00;
	localparam logic [4:0] RCPT_IFACE = 5'h01;
	localparam logic [4:0] RCPT_EP = 5'h02;
	localparam logic [15:0] FEAT_EP_HALT = 16'h0000;
	localparam logic [15:0] FEAT_REMOTE_WAKE = 16'h0001;
	localparam int STS_SELF_POWERED = 0;
	localparam int STS_REMOTE_WAKE = 1;
	localparam int STS_HALT = 0;

	// ****************************************
	// Reset values and reply lengths
	// ****************************************
	localparam logic [6:0] ADDR_RST = 7'h00;
	localparam logic [3:0] SEL_RST = 4'h0;
	localparam logic [1:0] LEN_NONE = 2'h0;
	localparam logic [1:0] LEN_BYTE = 2'h1;
	localparam logic [1:0] LEN_WORD = 2'h2;

	// Request classes after decoding
	typedef enum logic [3:0] {
		K_GET_STATUS,
		K_CLEAR_FEATURE,
		K_SET_FEATURE,
		K_SET_ADDRESS,
		K_GET_CONFIG,
		K_SET_CONFIG,
		K_GET_IFACE,
		K_SET_IFACE,
		K_FORWARD,
		K_IGNORE
	} req_kind_t;

	// Control transfer progress
	typedef enum logic [2:0] {
		S_IDLE,
		S_DECODE,
		S_HW_DONE,
		S_ADDR_WAIT,
		S_CPU_WAIT
	} xfer_state_t;

endpackage

/* File: include/req_if.sv */
// Decoded setup request carried from the decoder to the handler core
interface req_if;
	logic valid;
	usb_req_pkg::req_kind_t kind;
	logic [4:0] recipient;
	logic [15:0] w_value;
	logic [15:0] w_index;

	modport dec (
		output valid,
		output kind,
		output recipient,
		output w_value,
		output w_index
	);

	modport core (
		input valid,
		input kind,
		input recipient,
		input w_value,
		input w_index
	);
endinterface

/* File: rtl/req_decoder.sv */
// Classifies an incoming setup packet into a request kind
module req_decoder (
	input wire logic clk,
	input wire logic rst,
	input wire logic setup_valid,
	input wire logic [63:0] setup_data,
	req_if.dec rq
);

	logic [7:0] bmrt;
	logic [7:0] breq;
	usb_req_pkg::req_kind_t kind_nxt;
	usb_req_pkg::req_kind_t kind_r;
	logic valid_r;
	logic [4:0] rcpt_r;
	logic [15:0] wval_r;
	logic [15:0] widx_r;

	assign bmrt = setup_data[usb_req_pkg::BMRT_LSB +: 8];
	assign breq = setup_data[usb_req_pkg::BREQ_LSB +: 8];

	// Class and vendor requests go to firmware like forwarded standard ones
	always_comb begin
		kind_nxt = usb_req_pkg::K_IGNORE;
		if (bmrt[usb_req_pkg::TYPE_LSB +: 2] != usb_req_pkg::TYPE_STANDARD) begin
			kind_nxt = usb_req_pkg::K_FORWARD; // R21
		end else begin
			case (breq)
				usb_req_pkg::REQ_GET_STATUS: kind_nxt = usb_req_pkg::K_GET_STATUS;
				usb_req_pkg::REQ_CLEAR_FEATURE: kind_nxt = usb_req_pkg::K_CLEAR_FEATURE;
				usb_req_pkg::REQ_SET_FEATURE: kind_nxt = usb_req_pkg::K_SET_FEATURE;
				usb_req_pkg::REQ_SET_ADDRESS: kind_nxt = usb_req_pkg::K_SET_ADDRESS;
				usb_req_pkg::REQ_GET_DESCRIPTOR: kind_nxt = usb_req_pkg::K_FORWARD; // R9
				usb_req_pkg::REQ_SET_DESCRIPTOR: kind_nxt = usb_req_pkg::K_FORWARD; // R1
				usb_req_pkg::REQ_SYNCH_FRAME: kind_nxt = usb_req_pkg::K_FORWARD; // R1
				usb_req_pkg::REQ_GET_CONFIG: kind_nxt = usb_req_pkg::K_GET_CONFIG;
				usb_req_pkg::REQ_SET_CONFIG: kind_nxt = usb_req_pkg::K_SET_CONFIG;
				usb_req_pkg::REQ_GET_IFACE: kind_nxt = usb_req_pkg::K_GET_IFACE;
				usb_req_pkg::REQ_SET_IFACE: kind_nxt = usb_req_pkg::K_SET_IFACE;
				default: kind_nxt = usb_req_pkg::K_IGNORE;
			endcase
		end
	end

	// One register stage between the packet and the handler
	always_ff @(posedge clk) begin
		if (rst) begin
			valid_r <= 1'b0;
			kind_r <= usb_req_pkg::K_IGNORE;
			rcpt_r <= 5'h00;
			wval_r <= 16'h0000;
			widx_r <= 16'h0000;
		end else begin
			valid_r <= setup_valid;
			kind_r <= kind_nxt;
			rcpt_r <= bmrt[4:0];
			wval_r <= setup_data[usb_req_pkg::WVAL_LSB +: 16];
			widx_r <= setup_data[usb_req_pkg::WIDX_LSB +: 16];
		end
	end

	assign rq.valid = valid_r;
	assign rq.kind = kind_r;
	assign rq.recipient = rcpt_r;
	assign rq.w_value = wval_r;
	assign rq.w_index = widx_r;

endmodule

/* File: rtl/alt_setting_store.sv */
// Per-interface record of the selected alternate setting
module alt_setting_store #(
	parameter int IFACES = 16,
	parameter int ALT_W = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clear_all,
	input wire logic wr_en,
	input wire logic [3:0] wr_idx,
	input wire logic [ALT_W-1:0] wr_alt,
	input wire logic [3:0] rd_idx,
	output logic [ALT_W-1:0] rd_alt
);

	logic [ALT_W-1:0] alt_r [IFACES];
	logic [ALT_W-1:0] alt_nxt [IFACES];

	// A new configuration returns every interface to its default setting
	always_comb begin
		for (int i = 0; i < IFACES; i++) begin
			alt_nxt[i] = alt_r[i];
			if (clear_all) begin
				alt_nxt[i] = '0;
			end else if (wr_en && (int'(wr_idx) == i)) begin
				alt_nxt[i] = wr_alt;
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < IFACES; i++) begin
			if (rst) begin
				alt_r[i] <= '0;
			end else begin
				alt_r[i] <= alt_nxt[i];
			end
		end
	end

	// Indices beyond the store read as the default setting
	assign rd_alt = (int'(rd_idx) < IFACES) ? alt_r[rd_idx] : '0;

endmodule

/* File: bench/host_model.sv */
// Host side model that issues setup packets and status stages to ep0
module host_model (
	input wire logic clk,
	input wire logic status_ack,
	input wire logic status_nak,
	output logic setup_valid,
	output logic [63:0] setup_data,
	output logic [6:0] setup_dev_addr,
	output logic status_req,
	output logic status_done
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle levels before the first transfer
	initial begin
		setup_valid = 1'b0;
		setup_data = 64'h0;
		setup_dev_addr = 7'h00;
		status_req = 1'b0;
		status_done = 1'b0;
	end

	// Setup pulse; fields turn to garbage once it passes so stale values never count
	// Returns in the cycle where the one-cycle pulses of the request stand
	task automatic setup(input logic [63:0] d, input logic [6:0] a);
		@(negedge clk);
		setup_valid = 1'b1;
		setup_data = d;
		setup_dev_addr = a;
		@(negedge clk);
		setup_valid = 1'b0;
		setup_data = ~d;
		setup_dev_addr = ~a;
		@(negedge clk);
	endtask

	// Status token; the answer stands one cycle, so it is taken at the next falling edge
	task automatic status(output logic ack, output logic nak);
		@(negedge clk);
		status_req = 1'b1;
		@(negedge clk);
		status_req = 1'b0;
		ack = status_ack;
		nak = status_nak;
		if (ack) begin
			status_done = 1'b1;
			@(negedge clk);
			status_done = 1'b0;
		end
	endtask
endmodule

/* File: bench/usb_req_chk.sv */
// Port assertions for the standard request handler
module usb_req_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic setup_valid,
	input wire logic status_req,
	input wire logic status_done,
	input wire logic ep0_status_ack_enable,
	input wire logic [6:0] match_addr,
	input wire logic setup_irq,
	input wire logic data_flags_clear,
	input wire logic status_stage_irq,
	input wire logic selection_change_irq,
	input wire logic get_iface_seen,
	input wire logic status_ack,
	input wire logic status_nak,
	input wire logic reply_valid,
	input wire logic [3:0] active_cfg,
	input wire logic [3:0] active_iface,
	input wire logic [3:0] active_alt,
	input wire logic configured,
	input wire logic [15:0] ep_halt
);
	// ****************************************
	// Handshake and state relations
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_ANSWER_CAUSE: assert property ((status_ack || status_nak) |-> $past(status_req))
		else $error("status handshake without a status token");
	AST_ONE_ANSWER: assert property (status_req |=> (status_ack ^ status_nak))
		else $error("status token not answered exactly once");
	AST_STI_NAK: assert property (status_stage_irq |-> status_nak && !$past(ep0_status_ack_enable))
		else $error("status interrupt without a refused status stage");
	// Address moves only on a setup, a completed status stage or reset
	AST_ADDR_HOLD: assert property ($changed(match_addr) |-> $past(setup_valid) || $past(setup_valid, 2) || $past(status_done) || $past(rst))
		else $error("device address changed early");
	AST_FWD_FLAGS: assert property (setup_irq |-> data_flags_clear && $past(setup_valid, 2) && !reply_valid)
		else $error("forwarded setup signalled wrongly");
	AST_SEL_CAUSE: assert property (selection_change_irq |-> $past(setup_valid, 2) && (!$stable(active_cfg) || !$stable(active_iface) || !$stable(active_alt)))
		else $error("selection interrupt without a change");
	AST_SEL_IRQ: assert property ((!$stable(active_cfg) || !$stable(active_iface) || !$stable(active_alt)) |-> selection_change_irq || $past(rst))
		else $error("selection changed silently");
	AST_CFG_ZERO: assert property (configured == (active_cfg != 4'h0))
		else $error("configured flag disagrees with configuration");
	AST_GETIF_NOTE: assert property (get_iface_seen |-> reply_valid && !setup_irq)
		else $error("get interface not answered locally");
	AST_HALT_CAUSE: assert property (!$stable(ep_halt) |-> $past(setup_valid, 2) || $past(rst))
		else $error("halt changed without a request");
endmodule

bind usb_std_request_handler usb_req_chk chk (.clk, .rst, .setup_valid, .status_req, .status_done,
	.ep0_status_ack_enable, .match_addr, .setup_irq, .data_flags_clear, .status_stage_irq,
	.selection_change_irq, .get_iface_seen, .status_ack, .status_nak, .reply_valid,
	.active_cfg, .active_iface, .active_alt, .configured, .ep_halt);

/* File: bench/usb_std_request_handler_tb.sv */
// Self-checking bench for the standard request handler
module usb_std_request_handler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] ACK = 2'b10;
	localparam logic [1:0] NAK = 2'b01;
	logic clk, rst, ep0_status_ack_enable, self_powered;
	logic setup_valid, status_req, status_done, setup_irq, data_flags_clear;
	logic status_stage_irq, selection_change_irq, get_iface_seen, status_ack, status_nak;
	logic reply_valid, configured, remote_wake_en;
	logic [63:0] setup_data;
	logic [6:0] setup_dev_addr, match_addr, addr;
	logic [15:0] iface_status, reply_data, ep_halt;
	logic [1:0] reply_len;
	logic [3:0] active_cfg, active_iface, active_alt;
	logic [15:0] fwd [5];
	int errors, n_compared;

	usb_std_request_handler DUT (.clk, .rst, .setup_valid, .setup_data, .setup_dev_addr,
		.status_req, .status_done, .ep0_status_ack_enable, .self_powered, .iface_status,
		.match_addr, .setup_irq, .data_flags_clear, .status_stage_irq, .selection_change_irq,
		.get_iface_seen, .status_ack, .status_nak, .reply_valid, .reply_data, .reply_len,
		.active_cfg, .active_iface, .active_alt, .configured, .ep_halt, .remote_wake_en);
	host_model host (.clk, .status_ack, .status_nak, .setup_valid, .setup_data,
		.setup_dev_addr, .status_req, .status_done);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Setup packet, wLength unused so left zero
	task automatic req(input logic [7:0] t, input logic [7:0] b, input logic [15:0] v,
		input logic [15:0] i);
		host.setup({16'h0000, i, v, b, t}, addr);
	endtask
	task automatic st(input logic [1:0] exp);
		logic a, n;
		host.status(a, n);
		chk({a, n}, exp);
	endtask
	task automatic test_done();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Generous bound; the whole sequence needs well under a thousand cycles
	initial begin
		#100000;
		errors++;
		test_done();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		ep0_status_ack_enable = 1'b0;
		self_powered = 1'b1;
		iface_status = 16'h00a5;
		addr = 7'h00;
		fwd = '{{8'h80, usb_req_pkg::REQ_GET_DESCRIPTOR}, {8'h00, usb_req_pkg::REQ_SET_DESCRIPTOR},
			{8'h82, usb_req_pkg::REQ_SYNCH_FRAME}, 16'h2109, 16'h4001};
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk({active_cfg, active_iface, active_alt, configured, remote_wake_en}, 16'h0);
		chk(match_addr, 7'h00);
		chk(ep_halt, 16'h0000);
		st(NAK);
		// Unconfigured device: zero configuration, empty interface reply, no stall
		req(8'h80, usb_req_pkg::REQ_GET_CONFIG, 16'h0, 16'h0);
		chk({reply_valid, reply_len, reply_data[7:0]}, {1'b1, usb_req_pkg::LEN_BYTE, 8'h00});
		st(ACK);
		req(8'h81, usb_req_pkg::REQ_GET_IFACE, 16'h0, 16'h0);
		chk({get_iface_seen, setup_irq, reply_valid, reply_len}, {3'b101, usb_req_pkg::LEN_NONE});
		req(8'h01, usb_req_pkg::REQ_SET_IFACE, 16'h1, 16'h2);
		chk({selection_change_irq, active_iface, active_alt}, 16'h0);
		st(ACK);
		// New address only after the status stage completes
		req(8'h00, usb_req_pkg::REQ_SET_ADDRESS, 16'h5, 16'h0);
		chk(match_addr, 7'h00);
		st(ACK);
		@(negedge clk);
		chk(match_addr, 7'h05);
		addr = 7'h05;
		req(8'h00, usb_req_pkg::REQ_SET_CONFIG, 16'h2, 16'h0);
		chk({selection_change_irq, configured, active_cfg, setup_irq}, {2'b11, 4'h2, 1'b0});
		chk(match_addr, 7'h05);
		st(ACK);
		req(8'h80, usb_req_pkg::REQ_GET_CONFIG, 16'h0, 16'h0);
		chk({reply_len, reply_data[7:0]}, {usb_req_pkg::LEN_BYTE, 8'h02});
		req(8'h01, usb_req_pkg::REQ_SET_IFACE, 16'h4, 16'h3);
		chk({selection_change_irq, active_iface, active_alt}, {1'b1, 4'h3, 4'h4});
		st(ACK);
		req(8'h81, usb_req_pkg::REQ_GET_IFACE, 16'h0, 16'h3);
		chk({get_iface_seen, reply_len, reply_data[7:0]}, {1'b1, usb_req_pkg::LEN_BYTE, 8'h04});
		// Halt and remote wakeup, each read back through get-status
		req(8'h02, usb_req_pkg::REQ_SET_FEATURE, usb_req_pkg::FEAT_EP_HALT, 16'h3);
		chk(ep_halt, 16'h0008);
		st(ACK);
		req(8'h82, usb_req_pkg::REQ_GET_STATUS, 16'h0, 16'h3);
		chk({reply_len, reply_data}, {usb_req_pkg::LEN_WORD, 16'h0001});
		req(8'h02, usb_req_pkg::REQ_CLEAR_FEATURE, usb_req_pkg::FEAT_EP_HALT, 16'h3);
		chk(ep_halt, 16'h0000);
		req(8'h00, usb_req_pkg::REQ_SET_FEATURE, usb_req_pkg::FEAT_REMOTE_WAKE, 16'h0);
		chk(remote_wake_en, 1'b1);
		req(8'h80, usb_req_pkg::REQ_GET_STATUS, 16'h0, 16'h0);
		chk({reply_len, reply_data}, {usb_req_pkg::LEN_WORD, 16'h0003});
		req(8'h00, usb_req_pkg::REQ_CLEAR_FEATURE, usb_req_pkg::FEAT_REMOTE_WAKE, 16'h0);
		chk(remote_wake_en, 1'b0);
		req(8'h81, usb_req_pkg::REQ_GET_STATUS, 16'h0, 16'h3);
		chk({reply_len, reply_data}, {usb_req_pkg::LEN_WORD, 16'h00a5});
		// Forwarded requests: firmware must enable the status acknowledge first
		for (int k = 0; k < 5; k++) begin
			ep0_status_ack_enable = 1'b0;
			req(fwd[k][15:8], fwd[k][7:0], 16'h0100, 16'h0);
			chk({setup_irq, data_flags_clear, reply_valid}, 3'b110);
			st(NAK);
			chk(status_stage_irq, 1'b1);
			ep0_status_ack_enable = 1'b1;
			st(ACK);
		end
		// Second reset in mid-run
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk({match_addr, configured, active_cfg}, 16'h0);
		test_done();
	end
endmodule
